// >>> rtl/iss_pkg.sv
// Package: register map, field positions, reset values and timing counts of the synthesizer
package iss_pkg;
	localparam logic [11:0] ADDR_FB_DIV_LOW      = 12'h02A1;
	localparam logic [11:0] ADDR_FB_DIV_HIGH     = 12'h02A2;
	localparam logic [11:0] ADDR_OSC_GAIN_RES    = 12'h02A9;
	localparam logic [11:0] ADDR_OSC_CORE_BIAS   = 12'h02AA;
	localparam logic [11:0] ADDR_OSC_CAL_TRIGGER = 12'h02AB;
	localparam logic [11:0] ADDR_PUMP_CURRENT    = 12'h02AC;
	localparam logic [11:0] ADDR_PUMP_CAL_TRIG   = 12'h02AD;
	localparam logic [11:0] ADDR_OSC_VARACTOR    = 12'h02B7;
	localparam logic [11:0] ADDR_REF_DIV_SEL     = 12'h02BB;
	localparam logic [11:0] ADDR_CAL_LOCK_STATUS = 12'h02BC;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	localparam int REF_DIV_MSB    = 7;
	localparam int REF_DIV_LSB    = 6;
	localparam int STAT_PUMP_DONE = 0;
	localparam int STAT_OSC_BUSY  = 1;
	localparam int STAT_LOCKED    = 3;

	// Reference divider codes
	localparam logic [1:0] REF_DIV1 = 2'h0;
	localparam logic [1:0] REF_DIV2 = 2'h1;
	localparam logic [1:0] REF_DIV4 = 2'h2;
	localparam logic [1:0] REF_MUL2 = 2'h3;

	localparam logic [5:0] PUMP_CODE_MAX = 6'h3F;

	// Clock rate and calibration durations at the lowest comparison frequency
	localparam int CLK_HZ          = 10_000_000;
	localparam int PUMP_CAL_US     = 4000;
	localparam int OSC_CAL_US      = 2000;
	localparam int PUMP_CAL_CYCLES = PUMP_CAL_US * (CLK_HZ / 1_000_000);
	localparam int OSC_CAL_CYCLES  = OSC_CAL_US * (CLK_HZ / 1_000_000);
	localparam int LOCK_CYCLES     = 16;
	localparam int CNT_W           = 20;

	typedef enum logic [1:0] {ISS_IDLE, ISS_PUMP_CAL, ISS_OSC_CAL, ISS_LOCKING} iss_state_t;
endpackage

// >>> rtl/iss_cal_timer.sv
// Calibration timer: counts down a loaded cycle count and flags zero
`timescale 1ns/100ps
module iss_cal_timer
	import iss_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] count_i,
	output logic                  zero_o
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (load_i) begin
			next_count = count_i;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign zero_o = (count == '0);
endmodule

// >>> rtl/iss_synth_sequencer.sv
// Integer-N synthesizer configuration registers, calibration sequencer and lock status
// Notes on behaviour
// (RULE1) Loop makes a 2.94 to 3.2 GHz converter clock from 10-320 MHz reference.
// (RULE2) Host keeps the comparison frequency within 10 to 80 MHz.
// (RULE3) Reference divider bits 7:6 decode to 1, 2, 4 or multiply by 2.
// (RULE4) Feedback count is twice converter clock over comparison frequency.
// (RULE5) Feedback divider low and high bytes combine into one count.
// (RULE6) Host loads pump current code, at most 63.
// (RULE7) Write to pump trigger register starts pump calibration.
// (RULE8) Status bit 0 sets when pump calibration has finished.
// (RULE9) Host waits at most 4 ms pump calibration at slowest comparison.
// (RULE10) Write to oscillator trigger register starts oscillator calibration.
// (RULE11) Status bit 1 high while oscillator calibration runs.
// (RULE12) Host allows 2 ms oscillator calibration at slowest comparison.
// (RULE13) Status bit 3 reports loop lock.
// (RULE14) Host configures synthesizer before enabling other blocks.
// (RULE15) Host waits for each calibration step before the next command.
// (RULE16) Host writes bias and varactor codes for the frequency range.
// (RULE17) At 3200 MHz host writes extra gain and pump codes.
// (RULE18) Status register read-only; done bits hold until next trigger.
`timescale 1ns/100ps
module iss_synth_sequencer
	import iss_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic [7:0]       reg_rdata_o,
	output logic [15:0]      feedback_count_o,
	output logic [1:0]       ref_div_code_o,
	output logic [3:0]       ref_div_ratio_x2_o,
	output logic [5:0]       pump_current_code_o,
	output logic [7:0]       oscillator_gain_o,
	output logic [7:0]       oscillator_bias_o,
	output logic [7:0]       oscillator_varactor_o,
	output logic             pump_cal_busy_o,
	output logic             osc_cal_busy_o,
	output logic             locked_o
);
	logic [7:0] fb_low, fb_high, gain_res, core_bias, osc_trig, pump_cur, pump_trig;
	logic [7:0] varactor, ref_sel, rdata;
	logic [7:0] next_fb_low, next_fb_high, next_gain_res, next_core_bias, next_osc_trig;
	logic [7:0] next_pump_cur, next_pump_trig, next_varactor, next_ref_sel, next_rdata;
	logic       pump_done, osc_busy, locked;
	logic       next_pump_done, next_osc_busy, next_locked;
	iss_state_t state, next_state;
	logic             tmr_load;
	logic [CNT_W-1:0] tmr_count;
	logic             tmr_zero;
	logic             wr_pump, wr_osc;

	assign wr_pump = reg_wr_i && (reg_addr_i == ADDR_PUMP_CAL_TRIG);
	assign wr_osc  = reg_wr_i && (reg_addr_i == ADDR_OSC_CAL_TRIGGER);

	iss_cal_timer u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (tmr_load),
		.count_i   (tmr_count),
		.zero_o    (tmr_zero)
	);

	// Register writes; status address is absent so writes to it are dropped
	always_comb begin
		next_fb_low    = fb_low;
		next_fb_high   = fb_high;
		next_gain_res  = gain_res;
		next_core_bias = core_bias;
		next_osc_trig  = osc_trig;
		next_pump_cur  = pump_cur;
		next_pump_trig = pump_trig;
		next_varactor  = varactor;
		next_ref_sel   = ref_sel;
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_FB_DIV_LOW:      next_fb_low = reg_wdata_i; // RULE5
				ADDR_FB_DIV_HIGH:     next_fb_high = reg_wdata_i; // RULE5
				ADDR_OSC_GAIN_RES:    next_gain_res = reg_wdata_i;
				ADDR_OSC_CORE_BIAS:   next_core_bias = reg_wdata_i;
				ADDR_OSC_CAL_TRIGGER: next_osc_trig = reg_wdata_i;
				ADDR_PUMP_CURRENT:    next_pump_cur = reg_wdata_i;
				ADDR_PUMP_CAL_TRIG:   next_pump_trig = reg_wdata_i;
				ADDR_OSC_VARACTOR:    next_varactor = reg_wdata_i;
				ADDR_REF_DIV_SEL:     next_ref_sel = reg_wdata_i;
				default:              next_fb_low = fb_low; // RULE18
			endcase
		end
	end

	// Read mux, registered; unmapped addresses read zero
	always_comb begin
		next_rdata = rdata;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_FB_DIV_LOW:      next_rdata = fb_low;
				ADDR_FB_DIV_HIGH:     next_rdata = fb_high;
				ADDR_OSC_GAIN_RES:    next_rdata = gain_res;
				ADDR_OSC_CORE_BIAS:   next_rdata = core_bias;
				ADDR_OSC_CAL_TRIGGER: next_rdata = osc_trig;
				ADDR_PUMP_CURRENT:    next_rdata = pump_cur;
				ADDR_PUMP_CAL_TRIG:   next_rdata = pump_trig;
				ADDR_OSC_VARACTOR:    next_rdata = varactor;
				ADDR_REF_DIV_SEL:     next_rdata = ref_sel;
				ADDR_CAL_LOCK_STATUS: begin
					next_rdata = RESET_BYTE;
					next_rdata[STAT_PUMP_DONE] = pump_done; // RULE8
					next_rdata[STAT_OSC_BUSY]  = osc_busy; // RULE11
					next_rdata[STAT_LOCKED]    = locked; // RULE13
				end
				default:              next_rdata = RESET_BYTE;
			endcase
		end
	end

	// Calibration sequencer; a new trigger restarts the timer and the step
	always_comb begin
		next_state     = state;
		next_pump_done = pump_done;
		next_osc_busy  = osc_busy;
		next_locked    = locked;
		tmr_load       = 1'b0;
		tmr_count      = '0;
		if (wr_pump) begin
			next_state     = ISS_PUMP_CAL; // RULE7
			next_pump_done = 1'b0; // RULE18
			next_osc_busy  = 1'b0;
			next_locked    = 1'b0;
			tmr_load       = 1'b1;
			tmr_count      = CNT_W'(PUMP_CAL_CYCLES);
		end else if (wr_osc) begin
			next_state    = ISS_OSC_CAL; // RULE10
			next_osc_busy = 1'b1; // RULE11
			next_locked   = 1'b0;
			tmr_load      = 1'b1;
			tmr_count     = CNT_W'(OSC_CAL_CYCLES);
		end else begin
			case (state)
				ISS_IDLE: next_state = ISS_IDLE;
				ISS_PUMP_CAL: begin
					if (tmr_zero) begin
						next_pump_done = 1'b1; // RULE8
						next_state     = ISS_IDLE;
					end
				end
				ISS_OSC_CAL: begin
					if (tmr_zero) begin
						next_osc_busy = 1'b0; // RULE11
						next_state    = ISS_LOCKING;
						tmr_load      = 1'b1;
						tmr_count     = CNT_W'(LOCK_CYCLES);
					end
				end
				ISS_LOCKING: begin
					// Lock only follows a completed oscillator calibration
					if (tmr_zero) begin
						next_locked = 1'b1; // RULE13
						next_state  = ISS_IDLE;
					end
				end
				default: next_state = ISS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fb_low    <= RESET_BYTE;
			fb_high   <= RESET_BYTE;
			gain_res  <= RESET_BYTE;
			core_bias <= RESET_BYTE;
			osc_trig  <= RESET_BYTE;
			pump_cur  <= RESET_BYTE;
			pump_trig <= RESET_BYTE;
			varactor  <= RESET_BYTE;
			ref_sel   <= RESET_BYTE;
			rdata     <= RESET_BYTE;
			pump_done <= 1'b0;
			osc_busy  <= 1'b0;
			locked    <= 1'b0;
			state     <= ISS_IDLE;
		end else begin
			fb_low    <= next_fb_low;
			fb_high   <= next_fb_high;
			gain_res  <= next_gain_res;
			core_bias <= next_core_bias;
			osc_trig  <= next_osc_trig;
			pump_cur  <= next_pump_cur;
			pump_trig <= next_pump_trig;
			varactor  <= next_varactor;
			ref_sel   <= next_ref_sel;
			rdata     <= next_rdata;
			pump_done <= next_pump_done;
			osc_busy  <= next_osc_busy;
			locked    <= next_locked;
			state     <= next_state;
		end
	end

	// Ratio times two, so the multiply-by-two code fits as 1 (half)
	always_comb begin
		case (ref_sel[REF_DIV_MSB:REF_DIV_LSB])
			REF_DIV1: ref_div_ratio_x2_o = 4'h2; // RULE3
			REF_DIV2: ref_div_ratio_x2_o = 4'h4; // RULE3
			REF_DIV4: ref_div_ratio_x2_o = 4'h8; // RULE3
			REF_MUL2: ref_div_ratio_x2_o = 4'h1; // RULE3
			default:  ref_div_ratio_x2_o = 4'h2;
		endcase
	end

	// Raw code kept as well for blocks that decode the field themselves
	assign ref_div_code_o        = ref_sel[REF_DIV_MSB:REF_DIV_LSB];
	assign feedback_count_o      = {fb_high, fb_low}; // RULE4 RULE1
	assign pump_current_code_o   = pump_cur[5:0] & PUMP_CODE_MAX;
	assign oscillator_gain_o     = gain_res;
	assign oscillator_bias_o     = core_bias;
	assign oscillator_varactor_o = varactor;
	assign reg_rdata_o           = rdata;
	assign pump_cal_busy_o       = (state == ISS_PUMP_CAL);
	assign osc_cal_busy_o        = osc_busy;
	assign locked_o              = locked;
endmodule

// >>> testbench/iss_synth_sequencer_asserts.sv
// Checker: port-level assertions of the synthesizer sequencer
`timescale 1ns/100ps
module iss_chk
	import iss_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        reg_wr_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [15:0] feedback_count_o,
	input wire logic [1:0]  ref_div_code_o,
	input wire logic [3:0]  ref_div_ratio_x2_o,
	input wire logic [5:0]  pump_current_code_o,
	input wire logic        pump_cal_busy_o,
	input wire logic        osc_cal_busy_o,
	input wire logic        locked_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence wr_to(logic [11:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence
	sequence lock_wait;
		!locked_o [*8] ##[1:16] locked_o;
	endsequence
	AST_FB_LOW: assert property (wr_to(ADDR_FB_DIV_LOW) |=>
		feedback_count_o[7:0] == $past(reg_wdata_i)) else $error("low divider byte lost");
	AST_FB_HIGH: assert property (wr_to(ADDR_FB_DIV_HIGH) |=>
		feedback_count_o[15:8] == $past(reg_wdata_i)) else $error("high divider byte lost");
	AST_REF_MAP: assert property (ref_div_ratio_x2_o ==
		((ref_div_code_o == REF_MUL2) ? 4'h1 : 4'h2 << ref_div_code_o)) else $error("bad ratio");
	AST_PUMP_CODE: assert property (wr_to(ADDR_PUMP_CURRENT) |=>
		pump_current_code_o == $past(reg_wdata_i[5:0])) else $error("pump code lost");
	AST_PUMP_START: assert property (wr_to(ADDR_PUMP_CAL_TRIG) |=>
		pump_cal_busy_o && !locked_o) else $error("pump cal not started");
	AST_OSC_START: assert property (wr_to(ADDR_OSC_CAL_TRIGGER) |=>
		osc_cal_busy_o && !locked_o) else $error("osc cal not started");
	AST_OSC_HOLD: assert property ($rose(osc_cal_busy_o) |->
		osc_cal_busy_o [*8]) else $error("osc busy too short");
	AST_LOCK: assert property ($fell(osc_cal_busy_o) |-> lock_wait)
		else $error("lock timing wrong");
	AST_RO: assert property (wr_to(ADDR_CAL_LOCK_STATUS) ##0 (locked_o && !osc_cal_busy_o)
		|=> locked_o && !osc_cal_busy_o) else $error("status changed by write");
endmodule

bind iss_synth_sequencer iss_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.feedback_count_o(feedback_count_o), .ref_div_code_o(ref_div_code_o),
	.ref_div_ratio_x2_o(ref_div_ratio_x2_o), .pump_current_code_o(pump_current_code_o),
	.pump_cal_busy_o(pump_cal_busy_o), .osc_cal_busy_o(osc_cal_busy_o), .locked_o(locked_o));

// >>> testbench/iss_host.sv
// Host model: single-cycle register writes and reads
`timescale 1ns/100ps
module iss_host (
	input  wire logic        clk_i,
	input  wire logic [7:0]  rdata_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic [11:0]      addr_o,
	output logic [7:0]       wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 12'h0000;
		wdata_o = 8'h00;
	end
	// Idle data inverted so a stale byte is never mistaken for a write
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule

// >>> testbench/testbench.sv
// Testbench: register map, calibration sequence and lock status
`timescale 1ns/100ps
module testbench;
	import iss_pkg::*;
	localparam logic [11:0] RW [7] = '{ADDR_FB_DIV_LOW, ADDR_FB_DIV_HIGH, ADDR_OSC_GAIN_RES,
		ADDR_OSC_CORE_BIAS, ADDR_PUMP_CURRENT, ADDR_OSC_VARACTOR, ADDR_REF_DIV_SEL};
	localparam int RX2 [4] = '{2, 4, 8, 1};
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        wr, rd, pbusy, obusy, lock;
	logic [11:0] addr;
	logic [7:0]  wdata, rdata, rv, gain, bias, vara;
	logic [15:0] fb;
	logic [1:0]  rcode;
	logic [3:0]  rx2;
	logic [5:0]  pcode;
	int          fail_count = 0;
	int          compares = 0;
	int          cyc = 0;
	int          n;
	int          mdl[int];
	always #50 clk_i = ~clk_i;
	iss_host host_u (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata));
	iss_synth_sequencer dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.feedback_count_o(fb), .ref_div_code_o(rcode), .ref_div_ratio_x2_o(rx2),
		.pump_current_code_o(pcode), .oscillator_gain_o(gain), .oscillator_bias_o(bias),
		.oscillator_varactor_o(vara), .pump_cal_busy_o(pbusy), .osc_cal_busy_o(obusy),
		.locked_o(lock));
	task automatic summarize();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_port(input logic [15:0] a, input logic [15:0] e);
		compares++;
		if (a !== e) begin
			fail_count++;
			$display("Error at %0t: port %h expected %h", $time, a, e);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		host_u.rd(a, v);
		compares++;
		if (v !== e) begin
			fail_count++;
			$display("Error at %0t: read %h expected %h", $time, v, e);
		end
	endtask
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		host_u.wr(a, d);
		if (mdl.exists(a)) mdl[a] = d;
	endtask
	// Ceiling covers both worst-case calibrations plus register traffic
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		void'($urandom(55060));
		foreach (RW[i]) mdl[RW[i]] = 0;
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		foreach (RW[i]) rdc(RW[i], RESET_BYTE);
		rdc(ADDR_CAL_LOCK_STATUS, 8'h00);
		for (int k = 0; k < 4; k++) begin
			foreach (RW[i]) w(RW[i], 8'($urandom));
			w(ADDR_REF_DIV_SEL, {2'(k), 6'($urandom)});
			foreach (RW[i]) rdc(RW[i], 8'(mdl[RW[i]]));
			chk_port(fb, 16'(mdl[ADDR_FB_DIV_HIGH] * 256 + mdl[ADDR_FB_DIV_LOW]));
			chk_port({10'h0, rcode, rx2}, 16'(k * 16 + RX2[k]));
			chk_port({10'h0, pcode}, 16'(mdl[ADDR_PUMP_CURRENT] % 64));
			chk_port({gain, vara}, 16'(mdl[ADDR_OSC_GAIN_RES] * 256 + mdl[ADDR_OSC_VARACTOR]));
			chk_port({8'h0, bias}, 16'(mdl[ADDR_OSC_CORE_BIAS]));
		end
		w(ADDR_REF_DIV_SEL, 8'h80);
		w(ADDR_FB_DIV_LOW, 8'h80);
		w(ADDR_FB_DIV_HIGH, 8'h00);
		w(ADDR_OSC_CORE_BIAS, 8'h37);
		w(ADDR_OSC_VARACTOR, 8'hD0);
		w(ADDR_OSC_GAIN_RES, 8'h2A);
		w(ADDR_PUMP_CURRENT, 8'h12);
		chk_port(fb, 16'h0080);
		w(ADDR_PUMP_CAL_TRIG, 8'h01);
		rdc(ADDR_CAL_LOCK_STATUS, 8'h00);
		n = 0;
		do begin
			host_u.rd(ADDR_CAL_LOCK_STATUS, rv);
			n++;
		end while (rv[0] !== 1'b1 && n < 20100);
		chk_port(16'(n >= 19900 && n <= 20050), 16'h0001);
		w(ADDR_OSC_CAL_TRIGGER, 8'h01);
		rdc(ADDR_CAL_LOCK_STATUS, 8'h03);
		n = 0;
		do begin
			host_u.rd(ADDR_CAL_LOCK_STATUS, rv);
			n++;
		end while (rv[1] !== 1'b0 && n < 10100);
		chk_port(16'(n >= 9900 && n <= 10050), 16'h0001);
		repeat (LOCK_CYCLES + 4) @(posedge clk_i);
		rdc(ADDR_CAL_LOCK_STATUS, 8'h09);
		chk_port({13'h0, lock, obusy, pbusy}, 16'h0004);
		rdc(ADDR_PUMP_CAL_TRIG, 8'h01);
		rdc(ADDR_OSC_CAL_TRIGGER, 8'h01);
		w(ADDR_CAL_LOCK_STATUS, 8'h00);
		rdc(ADDR_CAL_LOCK_STATUS, 8'h09);
		rdc(12'h02A0, 8'h00);
		// Reset after lock must clear the status bits and the low divider byte
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rdc(ADDR_CAL_LOCK_STATUS, 8'h00);
		rdc(ADDR_FB_DIV_LOW, RESET_BYTE);
		chk_port({13'h0, lock, obusy, pbusy}, 16'h0000);
		summarize();
	end
endmodule
